// ==== verilog/io_irq_defs.svh ====
// Constants of the I/O line interrupt-mode and write-lock block.
// Assumes 32-bit APB addresses compared whole; included by bare name.
`ifndef IO_IRQ_DEFS_SVH
`define IO_IRQ_DEFS_SVH
`define BLOCK_BASE 32'h400e_0e00
`define ADDR_EXTRA_ENABLE 32'h400e_0eb0
`define ADDR_EXTRA_DISABLE 32'h400e_0eb4
`define ADDR_EXTRA_MASK 32'h400e_0eb8
`define ADDR_EDGE_SELECT 32'h400e_0ec0
`define ADDR_LEVEL_SELECT 32'h400e_0ec4
`define ADDR_EDGE_LEVEL_STATUS 32'h400e_0ec8
`define ADDR_FALL_LOW_SELECT 32'h400e_0ed0
`define ADDR_RISE_HIGH_SELECT 32'h400e_0ed4
`define ADDR_POLARITY_STATUS 32'h400e_0ed8
`define ADDR_LOCK_MODE 32'h400e_0ee4
`define ADDR_LOCK_STATUS 32'h400e_0ee8
`define ADDR_HYSTERESIS 32'h400e_0f00
`define ADDR_DRIVE 32'h400e_0f10
`define ADDR_IRQ_STATUS 32'h400e_0f20
`define ADDR_IRQ_ENABLE 32'h400e_0f24
`define ADDR_IRQ_CLEAR 32'h400e_0f28
`define LOCK_ENABLE_BIT 0
`define LOCK_KEY_MSB 31
`define LOCK_KEY_LSB 8
`define VIOL_FLAG_BIT 0
`define VIOL_OFFSET_MSB 23
`define VIOL_OFFSET_LSB 8
`define LINE_RESET 32'h0000_0000
`endif

// ==== verilog/io_irq_pkg.sv ====
// Types of the I/O line interrupt-mode and write-lock block.
// Assumes nothing beyond a SystemVerilog compiler.
package io_irq_pkg;
  typedef logic [31:0] line_vec_t;
  typedef struct packed {
    line_vec_t sync1;
    line_vec_t sync2;
    line_vec_t prev;
    line_vec_t extra_mask;
    line_vec_t level_mode;
    line_vec_t rise_high;
    line_vec_t hyst_off;
    line_vec_t drive_high;
    line_vec_t irq_status;
    line_vec_t irq_enable;
    logic [31:0] prdata;
    logic [15:0] viol_offset;
    logic viol_flag;
    logic lock_enable;
    logic pready;
    logic pslverr;
    logic irq;
  } io_state_t;
endpackage

// ==== verilog/io_line_detect.sv ====
// One line's interrupt event detector.
// Assumes synchronised current and previous samples on the same clock.
`timescale 1ns/1ps
module io_line_detect import io_irq_pkg::*; (
  input logic cur,
  input logic prev,
  input logic extra_en,
  input logic level_mode,
  input logic rise_high,
  output logic event_hit
);
  always_comb begin
    if (!extra_en) begin
      event_hit = cur ^ prev;
    end else if (level_mode) begin
      event_hit = (cur == rise_high);
    end else if (rise_high) begin
      event_hit = cur & ~prev;
    end else begin
      event_hit = ~cur & prev;
    end
  end
endmodule // io_line_detect

// ==== verilog/io_line_irq_mode_and_protect.sv ====
// I/O line interrupt-mode selection, write lock, hysteresis and drive control.
// Assumes an APB master on pclk; io_in comes from pads, asynchronous.
`timescale 1ns/1ps
`include "io_irq_defs.svh"
module io_line_irq_mode_and_protect import io_irq_pkg::*; #(
  // Key value is arbitrary
  parameter logic [23:0] lock_key_value = 24'h5a_a5c3
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [31:0] io_in,
  output logic [31:0] hysteresis_off,
  output logic [31:0] drive_high,
  output logic irq
);
  io_state_t st;
  io_state_t next_st;
  line_vec_t line_event;
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic is_protected;
  logic lock_hit;
  logic key_ok;
  logic bad_access;
  logic [31:0] rd_value;
  logic [31:0] offset_full;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_line
      io_line_detect u_detect (
        .cur(st.sync2[gi]),
        .prev(st.prev[gi]),
        .extra_en(st.extra_mask[gi]),
        .level_mode(st.level_mode[gi]),
        .rise_high(st.rise_high[gi]),
        .event_hit(line_event[gi])
      );
    end
  endgenerate

  assign access = psel & penable & ~st.pready;
  assign done = psel & penable & st.pready;
  assign wr_done = done & pwrite;
  assign rd_done = done & ~pwrite;
  assign key_ok = (pwdata[`LOCK_KEY_MSB:`LOCK_KEY_LSB] == lock_key_value);
  assign offset_full = paddr - `BLOCK_BASE;
  assign lock_hit = wr_done & is_protected & st.lock_enable;

  always_comb begin
    is_protected = 1'b0;
    case (paddr)
      `ADDR_EXTRA_ENABLE, `ADDR_EXTRA_DISABLE, `ADDR_EDGE_SELECT, `ADDR_LEVEL_SELECT,
      `ADDR_FALL_LOW_SELECT, `ADDR_RISE_HIGH_SELECT, `ADDR_HYSTERESIS, `ADDR_DRIVE: begin
        is_protected = 1'b1;
      end
      default: begin
        is_protected = 1'b0;
      end
    endcase
  end

  // Read mux and access check
  always_comb begin
    rd_value = 32'h0000_0000;
    bad_access = 1'b0;
    case (paddr)
      `ADDR_EXTRA_ENABLE, `ADDR_EXTRA_DISABLE, `ADDR_EDGE_SELECT, `ADDR_LEVEL_SELECT,
      `ADDR_FALL_LOW_SELECT, `ADDR_RISE_HIGH_SELECT, `ADDR_IRQ_CLEAR: begin
        bad_access = ~pwrite;
      end
      `ADDR_EXTRA_MASK: begin
        rd_value = st.extra_mask;
        bad_access = pwrite;
      end
      `ADDR_EDGE_LEVEL_STATUS: begin
        rd_value = st.level_mode;
        bad_access = pwrite;
      end
      `ADDR_POLARITY_STATUS: begin
        rd_value = st.rise_high;
        bad_access = pwrite;
      end
      `ADDR_LOCK_MODE: begin
        rd_value[`LOCK_ENABLE_BIT] = st.lock_enable;
      end
      `ADDR_LOCK_STATUS: begin
        rd_value[`VIOL_FLAG_BIT] = st.viol_flag;
        rd_value[`VIOL_OFFSET_MSB:`VIOL_OFFSET_LSB] = st.viol_offset;
        bad_access = pwrite;
      end
      `ADDR_HYSTERESIS: begin
        rd_value = st.hyst_off;
      end
      `ADDR_DRIVE: begin
        rd_value = st.drive_high;
      end
      `ADDR_IRQ_STATUS: begin
        rd_value = st.irq_status;
        bad_access = pwrite;
      end
      `ADDR_IRQ_ENABLE: begin
        rd_value = st.irq_enable;
      end
      default: begin
        bad_access = 1'b1;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.sync1 = io_in;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    next_st.pready = access;
    next_st.pslverr = access & bad_access;
    if (access) begin
      next_st.prdata = rd_value;
    end
    // Set wins over clear
    if (wr_done && paddr == `ADDR_IRQ_CLEAR) begin
      next_st.irq_status = (st.irq_status & ~pwdata) | line_event;
    end else begin
      next_st.irq_status = st.irq_status | line_event;
    end
    if (wr_done && !lock_hit) begin
      case (paddr)
        `ADDR_EXTRA_ENABLE: begin
          next_st.extra_mask = st.extra_mask | pwdata;
        end
        `ADDR_EXTRA_DISABLE: begin
          next_st.extra_mask = st.extra_mask & ~pwdata;
        end
        `ADDR_EDGE_SELECT: begin
          next_st.level_mode = st.level_mode & ~pwdata;
        end
        `ADDR_LEVEL_SELECT: begin
          next_st.level_mode = st.level_mode | pwdata;
        end
        `ADDR_FALL_LOW_SELECT: begin
          next_st.rise_high = st.rise_high & ~pwdata;
        end
        `ADDR_RISE_HIGH_SELECT: begin
          next_st.rise_high = st.rise_high | pwdata;
        end
        `ADDR_LOCK_MODE: begin
          if (key_ok) begin
            next_st.lock_enable = pwdata[`LOCK_ENABLE_BIT];
          end
        end
        `ADDR_HYSTERESIS: begin
          next_st.hyst_off = pwdata;
        end
        `ADDR_DRIVE: begin
          next_st.drive_high = pwdata;
        end
        `ADDR_IRQ_ENABLE: begin
          next_st.irq_enable = pwdata;
        end
        default: begin
        end
      endcase
    end
    if (rd_done && paddr == `ADDR_LOCK_STATUS) begin
      next_st.viol_flag = 1'b0;
    end
    if (lock_hit) begin
      next_st.viol_flag = 1'b1;
      next_st.viol_offset = offset_full[15:0];
    end
    next_st.irq = |(next_st.irq_status & next_st.irq_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign hysteresis_off = st.hyst_off;
  assign drive_high = st.drive_high;
  assign irq = st.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  edge_select_a: assert property (wr_done && paddr == `ADDR_EDGE_SELECT && !st.lock_enable
    |=> (st.level_mode & $past(pwdata)) == 32'h0000_0000)
    else $error("edge select did not clear level mode");
  level_select_a: assert property (wr_done && paddr == `ADDR_LEVEL_SELECT && !st.lock_enable
    |=> (st.level_mode & $past(pwdata)) == $past(pwdata) && (st.level_mode & ~$past(pwdata)) ==
    ($past(st.level_mode) & ~$past(pwdata)))
    else $error("level select wrong");
  mode_readback_a: assert property (psel && penable && !st.pready && !pwrite
    && paddr == `ADDR_EDGE_LEVEL_STATUS |=> pready && prdata == $past(st.level_mode))
    else $error("edge/level readback wrong");
  fall_low_a: assert property (wr_done && paddr == `ADDR_FALL_LOW_SELECT && !st.lock_enable
    |=> (st.rise_high & $past(pwdata)) == 32'h0000_0000)
    else $error("fall/low select wrong");
  rise_high_a: assert property (wr_done && paddr == `ADDR_RISE_HIGH_SELECT && !st.lock_enable
    |=> (st.rise_high & $past(pwdata)) == $past(pwdata))
    else $error("rise/high select wrong");
  lock_key_a: assert property (wr_done && paddr == `ADDR_LOCK_MODE
    |=> st.lock_enable == ($past(key_ok) ? $past(pwdata[`LOCK_ENABLE_BIT]) : $past(st.lock_enable)))
    else $error("lock enable changed wrongly");
  key_zero_a: assert property (rd_done && paddr == `ADDR_LOCK_MODE
    |-> prdata[`LOCK_KEY_MSB:`LOCK_KEY_LSB] == 24'h00_0000)
    else $error("key field read nonzero");
  viol_clear_a: assert property (rd_done && paddr == `ADDR_LOCK_STATUS |=> !st.viol_flag)
    else $error("violation flag not cleared by read");
  viol_offset_a: assert property (lock_hit
    |=> st.viol_flag && st.viol_offset == $past(offset_full[15:0]))
    else $error("violation offset not recorded");
  locked_drop_a: assert property (lock_hit
    |=> $stable(st.hyst_off) && $stable(st.drive_high) && $stable(st.level_mode) && $stable(st.rise_high)
    && $stable(st.extra_mask))
    else $error("locked write took effect");
  drive_write_a: assert property (wr_done && paddr == `ADDR_DRIVE && !st.lock_enable
    |=> drive_high == $past(pwdata))
    else $error("drive write lost");
  both_edge_a: assert property (!st.extra_mask[0] && (st.sync2[0] != st.prev[0])
    |=> st.irq_status[0] && (irq || !st.irq_enable[0]))
    else $error("default both-edge event missed");

  edge_keep_a: assert property (wr_done && paddr == `ADDR_EDGE_SELECT && !st.lock_enable
    |=> (st.level_mode & ~$past(pwdata)) == ($past(st.level_mode) & ~$past(pwdata)))
    else $error("edge select touched unwritten lines");
  rise_keep_a: assert property (wr_done && paddr == `ADDR_RISE_HIGH_SELECT && !st.lock_enable
    |=> (st.rise_high & ~$past(pwdata)) == ($past(st.rise_high) & ~$past(pwdata)))
    else $error("rise select touched unwritten lines");
  polarity_readback_a: assert property (psel && penable && !st.pready && !pwrite
    && paddr == `ADDR_POLARITY_STATUS |=> pready && prdata == $past(st.rise_high))
    else $error("polarity readback wrong");
  lock_readback_a: assert property (psel && penable && !st.pready && !pwrite
    && paddr == `ADDR_LOCK_MODE |=> prdata[`LOCK_ENABLE_BIT] == $past(st.lock_enable))
    else $error("lock enable readback wrong");
  bad_key_keep_a: assert property (wr_done && paddr == `ADDR_LOCK_MODE && !key_ok
    |=> $stable(st.lock_enable))
    else $error("wrong key changed lock enable");
  status_readback_a: assert property (psel && penable && !st.pready && !pwrite
    && paddr == `ADDR_LOCK_STATUS |=> prdata[`VIOL_FLAG_BIT] == $past(st.viol_flag))
    else $error("violation flag readback wrong");
  viol_sticky_a: assert property (st.viol_flag && !(rd_done && paddr == `ADDR_LOCK_STATUS)
    |=> st.viol_flag)
    else $error("violation flag lost without read");
  offset_readback_a: assert property (psel && penable && !st.pready && !pwrite
    && paddr == `ADDR_LOCK_STATUS |=> prdata[`VIOL_OFFSET_MSB:`VIOL_OFFSET_LSB] == $past(st.viol_offset))
    else $error("violation offset readback wrong");
  hyst_write_a: assert property (wr_done && paddr == `ADDR_HYSTERESIS && !st.lock_enable
    |=> hysteresis_off == $past(pwdata))
    else $error("hysteresis write lost");
  hyst_readback_a: assert property (psel && penable && !st.pready && !pwrite
    && paddr == `ADDR_HYSTERESIS |=> prdata == $past(st.hyst_off))
    else $error("hysteresis readback wrong");
  drive_readback_a: assert property (psel && penable && !st.pready && !pwrite
    && paddr == `ADDR_DRIVE |=> prdata == $past(st.drive_high))
    else $error("drive readback wrong");
  locked_quiet_a: assert property (lock_hit
    |-> pready && !pslverr)
    else $error("locked write answered with error");
  level_hit_a: assert property (st.extra_mask[0] && st.level_mode[0] && (st.sync2[0] == st.rise_high[0])
    |=> st.irq_status[0])
    else $error("level event missed");
  level_quiet_a: assert property (st.extra_mask[0] && st.level_mode[0] && (st.sync2[0] != st.rise_high[0])
    |-> !line_event[0])
    else $error("level event on wrong level");
  rise_edge_a: assert property (st.extra_mask[0] && !st.level_mode[0] && st.rise_high[0]
    && st.sync2[0] && !st.prev[0] |=> st.irq_status[0])
    else $error("rising edge event missed");
  fall_edge_a: assert property (st.extra_mask[0] && !st.level_mode[0] && !st.rise_high[0]
    && !st.sync2[0] && st.prev[0] |=> st.irq_status[0])
    else $error("falling edge event missed");
  wrong_edge_a: assert property (st.extra_mask[0] && !st.level_mode[0] && !st.rise_high[0]
    && st.sync2[0] && !st.prev[0] |-> !line_event[0])
    else $error("event on unselected edge");
  mask_quiet_a: assert property (!st.extra_mask[0] && (st.sync2[0] == st.prev[0])
    |-> !line_event[0])
    else $error("both-edge event without change");

  lock_viol_c: cover property (lock_hit ##[1:20] rd_done && paddr == `ADDR_LOCK_STATUS);
  edge_override_c: cover property (wr_done && paddr == `ADDR_EDGE_SELECT && (st.level_mode & pwdata) != 32'h0000_0000);
  level_irq_c: cover property (st.extra_mask[1] && st.level_mode[1] && line_event[1] && st.irq_enable[1]);
  bad_key_c: cover property (wr_done && paddr == `ADDR_LOCK_MODE && !key_ok);
  irq_rise_c: cover property (!irq ##1 irq);
endmodule // io_line_irq_mode_and_protect

// ==== verification/pad_model.sv ====
// Pad model: external levels driven onto the I/O lines.
// Assumes the bench names the wanted levels; pads settle after a pclk edge.
`timescale 1ns/1ps
module pad_model (
  input wire logic pclk,
  input wire logic [31:0] want,
  output logic [31:0] io_in
);
  initial io_in = 32'h0000_0000;
  // Levels change just after an edge, unrelated to bus traffic
  always @(posedge pclk) begin
    io_in <= want;
  end
endmodule // pad_model

// ==== verification/tb.sv ====
// Bench of the interrupt-mode and write-lock block.
// Assumes the design's register map header and the pad model beside it.
`timescale 1ns/1ps
`include "io_irq_defs.svh"
module tb;
  // Key value is arbitrary
  localparam logic [23:0] key = 24'h5a_a5c3;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, want = 32'h0000_0000;
  logic [31:0] prdata, io_in, hysteresis_off, drive_high, q;
  logic pready, pslverr, irq, err;
  int fail_count = 0, comparisons = 0, cycles = 0;
  io_line_irq_mode_and_protect #(.lock_key_value(key)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_in(io_in), .hysteresis_off(hysteresis_off), .drive_high(drive_high), .irq(irq));
  pad_model pads (.pclk(pclk), .want(want), .io_in(io_in));
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Setup, access, hold until pready is seen at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, q, exp);
  endtask
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 10; i++) begin
      @(negedge pclk);
      if (irq === exp) break;
    end
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask
  task automatic t_reset();
    rdc("els", `ADDR_EDGE_LEVEL_STATUS, 32'h0000_0000);
    rdc("pol", `ADDR_POLARITY_STATUS, 32'h0000_0000);
    rdc("lock", `ADDR_LOCK_MODE, 32'h0000_0000);
    rdc("hyst", `ADDR_HYSTERESIS, 32'h0000_0000);
    chk("drive", drive_high, 32'h0000_0000);
  endtask
  task automatic t_mode();
    wr(`ADDR_LEVEL_SELECT, 32'h0000_00f0);
    rdc("els", `ADDR_EDGE_LEVEL_STATUS, 32'h0000_00f0);
    wr(`ADDR_EDGE_SELECT, 32'h0000_0030);
    rdc("els", `ADDR_EDGE_LEVEL_STATUS, 32'h0000_00c0);
    wr(`ADDR_LEVEL_SELECT, 32'h0000_0000);
    rdc("els", `ADDR_EDGE_LEVEL_STATUS, 32'h0000_00c0);
    wr(`ADDR_RISE_HIGH_SELECT, 32'h0000_ff00);
    rdc("pol", `ADDR_POLARITY_STATUS, 32'h0000_ff00);
    wr(`ADDR_FALL_LOW_SELECT, 32'h0000_0f00);
    rdc("pol", `ADDR_POLARITY_STATUS, 32'h0000_f000);
  endtask
  task automatic t_pads();
    wr(`ADDR_HYSTERESIS, 32'ha5a5_0f0f);
    rdc("hyst", `ADDR_HYSTERESIS, 32'ha5a5_0f0f);
    chk("hyst_out", hysteresis_off, 32'ha5a5_0f0f);
    wr(`ADDR_DRIVE, 32'h8000_0001);
    rdc("drive", `ADDR_DRIVE, 32'h8000_0001);
    chk("drive_out", drive_high, 32'h8000_0001);
  endtask
  task automatic t_irq();
    wr(`ADDR_IRQ_ENABLE, 32'h0000_0001);
    want[0] <= 1'b1;
    wait_irq(1'b1);
    rdc("irq_stat", `ADDR_IRQ_STATUS, 32'h0000_0001);
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    wait_irq(1'b0);
    want[0] <= 1'b0;
    wait_irq(1'b1);
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    wr(`ADDR_EXTRA_ENABLE, 32'h0000_0001);
    want[0] <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("irq_rise", {31'h0, irq}, 32'h0000_0000);
    want[0] <= 1'b0;
    wait_irq(1'b1);
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    wait_irq(1'b0);
    wr(`ADDR_RISE_HIGH_SELECT, 32'h0000_0001);
    want[0] <= 1'b1;
    wait_irq(1'b1);
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    wr(`ADDR_LEVEL_SELECT, 32'h0000_0001);
    wait_irq(1'b1);
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    @(negedge pclk);
    chk("irq_level", {31'h0, irq}, 32'h0000_0001);
    wr(`ADDR_FALL_LOW_SELECT, 32'h0000_0001);
    wr(`ADDR_IRQ_CLEAR, 32'h0000_0001);
    wait_irq(1'b0);
  endtask
  task automatic t_lock();
    wr(`ADDR_LOCK_MODE, {~key, 8'h01});
    rdc("lock", `ADDR_LOCK_MODE, 32'h0000_0000);
    wr(`ADDR_LOCK_MODE, {key, 8'h01});
    rdc("lock", `ADDR_LOCK_MODE, 32'h0000_0001);
    wr(`ADDR_HYSTERESIS, 32'h0000_0000);
    chk("hyst_err", {31'h0, err}, 32'h0000_0000);
    rdc("hyst", `ADDR_HYSTERESIS, 32'ha5a5_0f0f);
    rdc("lstat", `ADDR_LOCK_STATUS, 32'h0001_0001);
    rdc("lstat", `ADDR_LOCK_STATUS, 32'h0001_0000);
    wr(`ADDR_LOCK_MODE, {key, 8'h00});
    rdc("lock", `ADDR_LOCK_MODE, 32'h0000_0000);
    wr(`ADDR_HYSTERESIS, 32'h0000_0000);
    rdc("hyst", `ADDR_HYSTERESIS, 32'h0000_0000);
  endtask
  task automatic t_bus();
    rdc("unmapped", 32'h400e_0efc, 32'h0000_0000);
    chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
    rdc("wo_read", `ADDR_EDGE_SELECT, 32'h0000_0000);
    chk("wo_err", {31'h0, err}, 32'h0000_0001);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode();
    t_pads();
    t_irq();
    t_lock();
    t_bus();
    results();
  end
endmodule // tb
